// >>> inc/clc_pkg.sv
package clc_pkg;

  // strap level as seen by the pin sensing front end
  typedef enum logic [1:0] {
    CLC_LVL_LOW,
    CLC_LVL_OPEN,
    CLC_LVL_HIGH,
    CLC_LVL_RES
  } clc_level_t;

  typedef enum logic [1:0] {
    CLC_SENSE_LOWSIDE,
    CLC_SENSE_DCR_DOWN,
    CLC_SENSE_DCR_UP
  } clc_sense_t;

  typedef enum logic [1:0] {
    CLC_COMP_HIGH_Q,
    CLC_COMP_REAL_ZEROS,
    CLC_COMP_LOW_Q
  } clc_comp_t;

  // clock and blanking times
  localparam int CLC_CLK_NS = 50;
  localparam int CLC_BLANK_LOWSIDE_NS = 672;
  localparam int CLC_BLANK_DCR_NS = 352;
  localparam int CLC_BLANK_W = 5;
  localparam logic [CLC_BLANK_W-1:0] CLC_BLANK_LOWSIDE_CYC =
    CLC_BLANK_W'((CLC_BLANK_LOWSIDE_NS + CLC_CLK_NS - 1) / CLC_CLK_NS);
  localparam logic [CLC_BLANK_W-1:0] CLC_BLANK_DCR_CYC =
    CLC_BLANK_W'((CLC_BLANK_DCR_NS + CLC_CLK_NS - 1) / CLC_CLK_NS);

  // resistor strap index: 0 is 10k, standard values upward
  localparam int CLC_RIDX_W = 5;
  localparam int CLC_GROUP_LOG = 3;
  localparam logic [CLC_RIDX_W-1:0] CLC_A_RES_MAX_IDX = 5'h14;
  localparam logic [CLC_RIDX_W-1:0] CLC_B_RES_MAX_IDX = 5'h17;

  // violation counts
  localparam int CLC_VIOL_W = 5;
  localparam logic [CLC_VIOL_W-1:0] CLC_VIOL_DEFAULT = 5'h04;

  // threshold in mV
  localparam int CLC_MV_W = 7;
  localparam int CLC_RES_STEP_MV = 5;
  localparam int CLC_TRI_BASE_MV = 20;
  localparam int CLC_TRI_A_STEP_MV = 10;
  localparam int CLC_TRI_B_STEP_MV = 30;

  // loop arithmetic
  localparam int CLC_DW = 12;
  localparam int CLC_COEF_W = 12;
  localparam int CLC_LOOP_SHIFT = 6;
  localparam int CLC_INTEG_LIM = 32'h000fffff;
  localparam int CLC_PWM_PERIOD_CYC = 40;

  // compensation presets (proportional, integral)
  localparam logic [CLC_COEF_W-1:0] CLC_KP_HIGH_Q = 12'h020;
  localparam logic [CLC_COEF_W-1:0] CLC_KI_HIGH_Q = 12'h004;
  localparam logic [CLC_COEF_W-1:0] CLC_KP_REAL = 12'h040;
  localparam logic [CLC_COEF_W-1:0] CLC_KI_REAL = 12'h008;
  localparam logic [CLC_COEF_W-1:0] CLC_KP_LOW_Q = 12'h018;
  localparam logic [CLC_COEF_W-1:0] CLC_KI_LOW_Q = 12'h002;

endpackage : clc_pkg

// >>> src/clc_pwm_loop.sv
`timescale 1ns/10ps
module clc_pwm_loop #(
  parameter int PERIOD_CYC = clc_pkg::CLC_PWM_PERIOD_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic en_i,
  input wire logic [clc_pkg::CLC_DW-1:0] vout_i,
  input wire logic [clc_pkg::CLC_DW-1:0] vref_i,
  input wire logic [clc_pkg::CLC_DW-1:0] band_i,
  input wire logic [clc_pkg::CLC_COEF_W-1:0] kp_i,
  input wire logic [clc_pkg::CLC_COEF_W-1:0] ki_i,
  // switch drive
  output logic hs_on_o,
  output logic ls_on_o,
  output logic period_start_o,
  output logic fast_up_o,
  output logic fast_down_o
);
  import clc_pkg::*;

  localparam int CW = $clog2(PERIOD_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
  localparam logic [CW-1:0] FULL = CW'(PERIOD_CYC);

  logic [CW-1:0] cnt_q, cnt_d, duty_q, duty_d;
  logic signed [31:0] integ_q, integ_d;
  logic hs_q, hs_d, ls_q, ls_d, up_q, up_d, dn_q, dn_d;
  logic signed [CLC_DW:0] err;
  logic signed [31:0] p_term, u;
  logic below, above;

  always_comb begin
    err = signed'({1'b0, vref_i}) - signed'({1'b0, vout_i});
    below = ({1'b0, vout_i} + {1'b0, band_i}) < {1'b0, vref_i};
    above = {1'b0, vout_i} > ({1'b0, vref_i} + {1'b0, band_i});
    p_term = 32'(err) * 32'(signed'({1'b0, kp_i}));
    u = (p_term + integ_q) >>> CLC_LOOP_SHIFT;
    cnt_d = (!en_i || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    integ_d = integ_q;
    duty_d = duty_q;
    if (!en_i) begin
      integ_d = '0;
      duty_d = '0;
    end else if (cnt_q == LAST && !below && !above) begin
      // integrate only inside the band; fast path bypasses it
      integ_d = integ_q + 32'(err) * 32'(signed'({1'b0, ki_i}));
      if (integ_d > CLC_INTEG_LIM) integ_d = CLC_INTEG_LIM;
      if (integ_d < -CLC_INTEG_LIM) integ_d = -CLC_INTEG_LIM;
      if (u < 0) duty_d = '0;
      else if (u > 32'(PERIOD_CYC)) duty_d = FULL;
      else duty_d = CW'(u);
    end
    up_d = en_i && below;
    dn_d = en_i && above;
    if (!en_i) begin
      hs_d = 1'b0;
      ls_d = 1'b0;
    end else if (below) begin
      hs_d = 1'b1;
      ls_d = 1'b0;
    end else if (above) begin
      hs_d = 1'b0;
      ls_d = 1'b1;
    end else begin
      hs_d = cnt_q < duty_q;
      ls_d = !(cnt_q < duty_q);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      duty_q <= '0;
      integ_q <= '0;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      duty_q <= duty_d;
      integ_q <= integ_d;
      hs_q <= hs_d;
      ls_q <= ls_d;
      up_q <= up_d;
      dn_q <= dn_d;
    end
  end

  assign hs_on_o = hs_q;
  assign ls_on_o = ls_q;
  assign fast_up_o = up_q;
  assign fast_down_o = dn_q;
  assign period_start_o = en_i && (cnt_q == '0);

endmodule : clc_pwm_loop

// >>> src/clc_limit_config.sv
// Contract
// - second strap resistor 10k..19.6k: low-side switch sensing, 672 ns blanking
// - second strap resistor 21.5k..42.2k: down-slope winding sensing, 352 ns blanking
// - second strap resistor 46.4k..90.9k: up-slope winding sensing, 352 ns blanking
// - position within eight-resistor group sets violation count 1..15, odd steps
// - both straps tri-level: ground sensing, threshold 20 + 10*a + 30*b mV
// - first strap resistor sets threshold in 5 mV steps, 0 to 100 mV
// - host write of threshold replaces strap threshold
// - compensation strap high/open/low picks high Q, real zeros, low Q
// - spare compensation strap is ignored completely
// - host write of compensation coefficients replaces strap preset
// - fixed-frequency voltage-mode loop integrates error into duty cycle
// - output below band forces high-side switch on
// - output above band forces low-side switch on
// - fast path bypasses integrator only outside band; linear loop inside
// - no current sample taken during blanking after each period start; one sample per period after that
// - second strap method decode valid only with first strap resistor
`timescale 1ns/10ps
module clc_limit_config #(
  parameter int PERIOD_CYC = clc_pkg::CLC_PWM_PERIOD_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // straps
  input wire clc_pkg::clc_level_t limit_strap_a_lvl_i,
  input wire logic [clc_pkg::CLC_RIDX_W-1:0] limit_strap_a_idx_i,
  input wire clc_pkg::clc_level_t limit_strap_b_lvl_i,
  input wire logic [clc_pkg::CLC_RIDX_W-1:0] limit_strap_b_idx_i,
  input wire clc_pkg::clc_level_t comp_strap_lvl_i,
  input wire clc_pkg::clc_level_t spare_comp_strap_lvl_i,
  // host overrides
  input wire logic host_limit_wr_i,
  input wire logic [clc_pkg::CLC_MV_W-1:0] host_limit_mv_i,
  input wire logic host_comp_wr_i,
  input wire logic [clc_pkg::CLC_COEF_W-1:0] host_kp_i,
  input wire logic [clc_pkg::CLC_COEF_W-1:0] host_ki_i,
  // converter samples
  input wire logic run_en_i,
  input wire logic [clc_pkg::CLC_DW-1:0] vout_i,
  input wire logic [clc_pkg::CLC_DW-1:0] vref_i,
  input wire logic [clc_pkg::CLC_DW-1:0] band_i,
  input wire logic [clc_pkg::CLC_MV_W-1:0] isense_mv_i,
  // configuration status
  output logic cfg_valid_o,
  output clc_pkg::clc_sense_t sense_method_o,
  output logic [clc_pkg::CLC_BLANK_W-1:0] blank_cyc_o,
  output logic [clc_pkg::CLC_VIOL_W-1:0] viol_limit_o,
  output logic [clc_pkg::CLC_MV_W-1:0] limit_mv_o,
  output clc_pkg::clc_comp_t comp_mode_o,
  output logic comp_host_o,
  // power stage
  output logic hs_on_o,
  output logic ls_on_o,
  output logic fast_up_o,
  output logic fast_down_o,
  output logic oc_fault_o
);
  import clc_pkg::*;

  typedef enum logic {CLC_ST_DECODE, CLC_ST_RUN} clc_state_t;

  function automatic logic [1:0] clc_tri_step(input clc_level_t l);
    unique case (l)
      CLC_LVL_LOW: clc_tri_step = 2'h0;
      CLC_LVL_OPEN: clc_tri_step = 2'h1;
      CLC_LVL_HIGH: clc_tri_step = 2'h2;
      CLC_LVL_RES: clc_tri_step = 2'h0;
    endcase
  endfunction : clc_tri_step

  function automatic logic [CLC_RIDX_W-1:0] clc_clamp_idx(input logic [CLC_RIDX_W-1:0] idx,
                                                          input logic [CLC_RIDX_W-1:0] lim);
    clc_clamp_idx = (idx > lim) ? lim : idx;
  endfunction : clc_clamp_idx

  function automatic logic [CLC_BLANK_W-1:0] clc_blank_of(input clc_sense_t m);
    clc_blank_of = (m == CLC_SENSE_LOWSIDE) ? CLC_BLANK_LOWSIDE_CYC : CLC_BLANK_DCR_CYC;
  endfunction : clc_blank_of

  // configuration state
  clc_state_t state_q, state_d;
  clc_sense_t method_q, method_d, dec_method;
  clc_comp_t comp_q, comp_d, dec_comp;
  logic [CLC_VIOL_W-1:0] viol_q, viol_d, dec_viol;
  logic [CLC_MV_W-1:0] mv_q, mv_d, dec_mv;
  logic [CLC_COEF_W-1:0] kp_q, kp_d, ki_q, ki_d, dec_kp, dec_ki;
  logic comp_host_q, comp_host_d;
  logic [CLC_RIDX_W-1:0] idx_a, idx_b;
  logic [CLC_GROUP_LOG-1:0] member;

  // strap decode
  always_comb begin
    idx_a = clc_clamp_idx(limit_strap_a_idx_i, CLC_A_RES_MAX_IDX);
    idx_b = clc_clamp_idx(limit_strap_b_idx_i, CLC_B_RES_MAX_IDX);
    member = idx_b[CLC_GROUP_LOG-1:0];
    dec_method = CLC_SENSE_LOWSIDE;
    dec_viol = CLC_VIOL_DEFAULT;
    dec_mv = CLC_MV_W'(CLC_TRI_BASE_MV + CLC_TRI_A_STEP_MV * int'(clc_tri_step(limit_strap_a_lvl_i)));
    if (limit_strap_a_lvl_i == CLC_LVL_RES) begin
      dec_mv = CLC_MV_W'(CLC_RES_STEP_MV * int'(idx_a));
      unique case (limit_strap_b_lvl_i)
        CLC_LVL_LOW: dec_method = CLC_SENSE_LOWSIDE;
        CLC_LVL_OPEN: dec_method = CLC_SENSE_DCR_DOWN;
        CLC_LVL_HIGH: dec_method = CLC_SENSE_DCR_UP;
        CLC_LVL_RES: begin
          unique case (idx_b[CLC_RIDX_W-1:CLC_GROUP_LOG])
            2'h0: dec_method = CLC_SENSE_LOWSIDE;
            2'h1: dec_method = CLC_SENSE_DCR_DOWN;
            default: dec_method = CLC_SENSE_DCR_UP;
          endcase
          dec_viol = CLC_VIOL_W'(2 * int'(member) + 1);
        end
      endcase
    end else if (limit_strap_b_lvl_i != CLC_LVL_RES) begin
      dec_mv = CLC_MV_W'(CLC_TRI_BASE_MV + CLC_TRI_A_STEP_MV * int'(clc_tri_step(limit_strap_a_lvl_i))
                         + CLC_TRI_B_STEP_MV * int'(clc_tri_step(limit_strap_b_lvl_i)));
    end
    // spare_comp_strap_lvl_i deliberately not read
    unique case (comp_strap_lvl_i)
      CLC_LVL_HIGH: begin
        dec_comp = CLC_COMP_HIGH_Q;
        dec_kp = CLC_KP_HIGH_Q;
        dec_ki = CLC_KI_HIGH_Q;
      end
      CLC_LVL_LOW: begin
        dec_comp = CLC_COMP_LOW_Q;
        dec_kp = CLC_KP_LOW_Q;
        dec_ki = CLC_KI_LOW_Q;
      end
      default: begin
        dec_comp = CLC_COMP_REAL_ZEROS;
        dec_kp = CLC_KP_REAL;
        dec_ki = CLC_KI_REAL;
      end
    endcase
  end

  // configuration next state
  always_comb begin
    state_d = state_q;
    method_d = method_q;
    viol_d = viol_q;
    mv_d = mv_q;
    comp_d = comp_q;
    kp_d = kp_q;
    ki_d = ki_q;
    comp_host_d = comp_host_q;
    unique case (state_q)
      CLC_ST_DECODE: begin
        // single capture of straps after reset
        method_d = dec_method;
        viol_d = dec_viol;
        mv_d = dec_mv;
        comp_d = dec_comp;
        kp_d = dec_kp;
        ki_d = dec_ki;
        comp_host_d = 1'b0;
        state_d = CLC_ST_RUN;
      end
      CLC_ST_RUN: begin
        if (host_limit_wr_i) mv_d = host_limit_mv_i;
        if (host_comp_wr_i) begin
          kp_d = host_kp_i;
          ki_d = host_ki_i;
          comp_host_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= CLC_ST_DECODE;
      method_q <= CLC_SENSE_LOWSIDE;
      viol_q <= CLC_VIOL_DEFAULT;
      mv_q <= '0;
      comp_q <= CLC_COMP_REAL_ZEROS;
      kp_q <= CLC_KP_REAL;
      ki_q <= CLC_KI_REAL;
      comp_host_q <= 1'b0;
    end else begin
      state_q <= state_d;
      method_q <= method_d;
      viol_q <= viol_d;
      mv_q <= mv_d;
      comp_q <= comp_d;
      kp_q <= kp_d;
      ki_q <= ki_d;
      comp_host_q <= comp_host_d;
    end
  end

  // current monitor state
  logic [CLC_BLANK_W-1:0] blank_q, blank_d;
  logic armed_q, armed_d;
  logic [CLC_VIOL_W-1:0] vcnt_q, vcnt_d;
  logic fault_q, fault_d;
  logic loop_en, period_start;

  assign loop_en = run_en_i && (state_q == CLC_ST_RUN) && !fault_q;

  always_comb begin
    blank_d = blank_q;
    armed_d = armed_q;
    vcnt_d = vcnt_q;
    fault_d = fault_q;
    if (!loop_en) begin
      blank_d = '0;
      armed_d = 1'b0;
      vcnt_d = '0;
    end else if (period_start) begin
      blank_d = clc_blank_of(method_q);
      armed_d = 1'b1;
    end else if (blank_q != '0) begin
      blank_d = blank_q - 1'b1;
    end else if (armed_q) begin
      armed_d = 1'b0;
      if (isense_mv_i > mv_q) begin
        vcnt_d = vcnt_q + 1'b1;
        if (vcnt_d >= viol_q) fault_d = 1'b1;
      end else begin
        vcnt_d = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      blank_q <= '0;
      armed_q <= 1'b0;
      vcnt_q <= '0;
      fault_q <= 1'b0;
    end else begin
      blank_q <= blank_d;
      armed_q <= armed_d;
      vcnt_q <= vcnt_d;
      fault_q <= fault_d;
    end
  end

  clc_pwm_loop #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_loop (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(loop_en),
    .vout_i(vout_i),
    .vref_i(vref_i),
    .band_i(band_i),
    .kp_i(kp_q),
    .ki_i(ki_q),
    .hs_on_o(hs_on_o),
    .ls_on_o(ls_on_o),
    .period_start_o(period_start),
    .fast_up_o(fast_up_o),
    .fast_down_o(fast_down_o)
  );

  assign cfg_valid_o = (state_q == CLC_ST_RUN);
  assign sense_method_o = method_q;
  assign blank_cyc_o = clc_blank_of(method_q);
  assign viol_limit_o = viol_q;
  assign limit_mv_o = mv_q;
  assign comp_mode_o = comp_q;
  assign comp_host_o = comp_host_q;
  assign oc_fault_o = fault_q;

endmodule : clc_limit_config

// >>> verification/clc_limit_config_sva.sv
`timescale 1ns/10ps
module clc_limit_config_sva #(
  parameter int PERIOD_CYC = 40
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // host and loop inputs
  input wire logic host_limit_wr_i,
  input wire logic [clc_pkg::CLC_MV_W-1:0] host_limit_mv_i,
  input wire logic host_comp_wr_i,
  input wire logic run_en_i,
  input wire logic [clc_pkg::CLC_DW-1:0] vout_i,
  input wire logic [clc_pkg::CLC_DW-1:0] vref_i,
  input wire logic [clc_pkg::CLC_DW-1:0] band_i,
  // design outputs
  input wire logic cfg_valid_o,
  input wire clc_pkg::clc_sense_t sense_method_o,
  input wire logic [clc_pkg::CLC_BLANK_W-1:0] blank_cyc_o,
  input wire logic [clc_pkg::CLC_VIOL_W-1:0] viol_limit_o,
  input wire logic [clc_pkg::CLC_MV_W-1:0] limit_mv_o,
  input wire clc_pkg::clc_comp_t comp_mode_o,
  input wire logic comp_host_o,
  input wire logic hs_on_o,
  input wire logic ls_on_o,
  input wire logic fast_up_o,
  input wire logic fast_down_o,
  input wire logic oc_fault_o
);
  import clc_pkg::*;
  logic act, below, above;
  assign act = run_en_i && cfg_valid_o && !oc_fault_o;
  assign below = {1'b0, vout_i} + {1'b0, band_i} < {1'b0, vref_i};
  assign above = {1'b0, vout_i} > {1'b0, vref_i} + {1'b0, band_i};
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_fast_up: assert property (act && below |=> fast_up_o && hs_on_o && !ls_on_o)
    else $error("fast up path not taken");
  chk_fast_down: assert property (act && above |=> fast_down_o && ls_on_o && !hs_on_o)
    else $error("fast down path not taken");
  chk_in_band: assert property (act && !below && !above |=> !fast_up_o && !fast_down_o)
    else $error("fast path active inside band");
  chk_loop_off: assert property (!run_en_i |=> !hs_on_o && !ls_on_o && !fast_up_o)
    else $error("switches driven while disabled");
  chk_no_overlap: assert property (!(hs_on_o && ls_on_o))
    else $error("both switches on");
  chk_pwm_compl: assert property (act && !below && !above |=> hs_on_o != ls_on_o)
    else $error("linear loop not driving exactly one switch");
  chk_host_limit: assert property (host_limit_wr_i && cfg_valid_o |=> limit_mv_o == $past(host_limit_mv_i))
    else $error("host threshold not taken");
  chk_host_comp: assert property (host_comp_wr_i && cfg_valid_o |=> comp_host_o)
    else $error("host compensation not taken");
  chk_cfg_hold: assert property (cfg_valid_o && !host_limit_wr_i |=> $stable(limit_mv_o)
    && $stable(sense_method_o) && $stable(viol_limit_o) && $stable(comp_mode_o))
    else $error("configuration changed without cause");
  chk_valid_up: assert property (!cfg_valid_o |=> cfg_valid_o)
    else $error("configuration not decoded after reset");
  chk_blank_map: assert property (blank_cyc_o ==
    (sense_method_o == CLC_SENSE_LOWSIDE ? 5'h0e : 5'h08))
    else $error("blanking does not match method");
  chk_fault_stick: assert property (oc_fault_o |=> oc_fault_o && !hs_on_o && !ls_on_o)
    else $error("fault not sticky");
endmodule : clc_limit_config_sva

bind clc_limit_config clc_limit_config_sva #(.PERIOD_CYC(PERIOD_CYC)) u_sva (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .host_limit_wr_i(host_limit_wr_i),
  .host_limit_mv_i(host_limit_mv_i), .host_comp_wr_i(host_comp_wr_i), .run_en_i(run_en_i),
  .vout_i(vout_i), .vref_i(vref_i), .band_i(band_i), .cfg_valid_o(cfg_valid_o),
  .sense_method_o(sense_method_o), .blank_cyc_o(blank_cyc_o), .viol_limit_o(viol_limit_o),
  .limit_mv_o(limit_mv_o), .comp_mode_o(comp_mode_o), .comp_host_o(comp_host_o), .hs_on_o(hs_on_o),
  .ls_on_o(ls_on_o), .fast_up_o(fast_up_o), .fast_down_o(fast_down_o), .oc_fault_o(oc_fault_o)
);

// >>> verification/clc_stage_model.sv
`timescale 1ns/10ps
module clc_stage_model #(
  parameter int RING_CYC = 5
) (
  // clock
  input wire logic sys_clk_i,
  // switch drive
  input wire logic hs_on_i,
  // operating point
  input wire logic [11:0] vbase_i,
  input wire logic [6:0] load_mv_i,
  // sensed values
  output logic [11:0] vout_o,
  output logic [6:0] isense_mv_o
);
  logic hs_q = 1'b0;
  logic hs_d;
  logic [3:0] ring_q = 4'h0;
  logic [3:0] ring_d;
  // ringing follows each high-side turn-on
  always_comb begin
    hs_d = hs_on_i;
    ring_d = ring_q == 4'h0 ? 4'h0 : ring_q - 4'h1;
    if (hs_on_i && !hs_q) ring_d = 4'(RING_CYC);
  end
  always_ff @(posedge sys_clk_i) begin
    hs_q <= hs_d;
    ring_q <= ring_d;
  end
  assign vout_o = vbase_i + {11'h000, hs_on_i};
  // ringing already shows in the turn-on cycle itself, so a missing blanking window is caught
  assign isense_mv_o = (ring_q != 4'h0 || (hs_on_i && !hs_q)) ? 7'h7f : load_mv_i;
endmodule : clc_stage_model

// >>> verification/clc_limit_config_tb.sv
`timescale 1ns/10ps
module clc_limit_config_tb;
  import clc_pkg::*;
  typedef struct packed {
    clc_sense_t m;
    logic [4:0] v;
    logic [6:0] mv;
    clc_comp_t cp;
    logic ch;
  } clc_exp_t;
  localparam int PER = 16;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  clc_level_t al = CLC_LVL_LOW, bl = CLC_LVL_LOW, cl = CLC_LVL_OPEN, sl = CLC_LVL_LOW;
  logic [4:0] ai = 5'h00, bi = 5'h00, bc, vl;
  logic lwr = 1'b0, cwr = 1'b0, run = 1'b0, cv, hs, ls, fu, fd, oc, ch;
  logic [6:0] lmv = 7'h00, load = 7'h00, isn, mv;
  logic [11:0] kp = 12'h000, ki = 12'h000, vb = 12'h400, vref = 12'h400, band = 12'h010, vout;
  clc_sense_t sm;
  clc_comp_t cm;
  clc_exp_t q[$];
  int mismatches = 0, samples_checked = 0, seed = 77;

  clc_limit_config #(.PERIOD_CYC(PER)) DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .limit_strap_a_lvl_i(al), .limit_strap_a_idx_i(ai),
    .limit_strap_b_lvl_i(bl), .limit_strap_b_idx_i(bi), .comp_strap_lvl_i(cl), .spare_comp_strap_lvl_i(sl),
    .host_limit_wr_i(lwr), .host_limit_mv_i(lmv), .host_comp_wr_i(cwr), .host_kp_i(kp), .host_ki_i(ki),
    .run_en_i(run), .vout_i(vout), .vref_i(vref), .band_i(band), .isense_mv_i(isn), .cfg_valid_o(cv),
    .sense_method_o(sm), .blank_cyc_o(bc), .viol_limit_o(vl), .limit_mv_o(mv), .comp_mode_o(cm),
    .comp_host_o(ch), .hs_on_o(hs), .ls_on_o(ls), .fast_up_o(fu), .fast_down_o(fd), .oc_fault_o(oc)
  );
  clc_stage_model u_stage (
    .sys_clk_i(sys_clk_i), .hs_on_i(hs), .vbase_i(vb), .load_mv_i(load), .vout_o(vout), .isense_mv_o(isn)
  );

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic wrap_up;
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic c, input string s);
    samples_checked++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask : chk

  function automatic clc_exp_t exp_of();
    clc_exp_t e;
    int b;
    e = '{CLC_SENSE_LOWSIDE, 5'h04, 7'h00, CLC_COMP_REAL_ZEROS, 1'b0};
    b = bi > 23 ? 23 : bi;
    if (cl == CLC_LVL_LOW) e.cp = CLC_COMP_LOW_Q;
    if (cl == CLC_LVL_HIGH) e.cp = CLC_COMP_HIGH_Q;
    if (al != CLC_LVL_RES) e.mv = 7'(20 + 10 * al + (bl == CLC_LVL_RES ? 0 : 30 * bl));
    else begin
      e.mv = 7'(5 * (ai > 20 ? 20 : ai));
      if (bl != CLC_LVL_RES) e.m = clc_sense_t'(bl);
      else begin
        e.m = clc_sense_t'(b / 8);
        e.v = 5'(2 * (b % 8) + 1);
      end
    end
    return e;
  endfunction : exp_of

  // reset, set straps, release and note the decoded result
  task automatic cfg(input clc_level_t a, input logic [4:0] x, input clc_level_t b, input logic [4:0] y,
                     input clc_level_t c);
    rst_n_i = 1'b0;
    al = a;
    ai = x;
    bl = b;
    bi = y;
    cl = c;
    sl = clc_level_t'(2'($random(seed)));
    q.push_back(exp_of());
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
  endtask : cfg

  // result watcher
  initial begin
    logic v0, c0;
    logic [6:0] m0;
    clc_exp_t e;
    v0 = 1'b0;
    c0 = 1'b0;
    m0 = 7'h00;
    forever begin
      @(negedge sys_clk_i);
      if (cv === 1'b1 && (v0 !== 1'b1 || mv !== m0 || ch !== c0)) begin
        chk(q.size() > 0, "unexpected update");
        if (q.size() > 0) begin
          e = q.pop_front();
          chk(sm === e.m && vl === e.v && mv === e.mv, "limit setup");
          chk(cm === e.cp && ch === e.ch, "compensation");
          chk(bc === (e.m == CLC_SENSE_LOWSIDE ? 5'h0e : 5'h08), "blanking");
        end
      end
      v0 = cv;
      m0 = mv;
      c0 = ch;
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    mismatches++;
    wrap_up;
  end

  initial begin
    clc_exp_t e;
    int w;
    repeat (6) @(negedge sys_clk_i);
    for (int i = 0; i < 24; i++) cfg(CLC_LVL_RES, 5'($random(seed)), CLC_LVL_RES, 5'(i), clc_level_t'(2'(i)));
    for (int i = 0; i < 12; i++)
      cfg(clc_level_t'(2'(i % 3)), 5'h00, clc_level_t'(2'(i / 3)), 5'h00, CLC_LVL_OPEN);
    for (int i = 0; i < 3; i++) cfg(CLC_LVL_RES, 5'h14, clc_level_t'(2'(i)), 5'h00, CLC_LVL_HIGH);
    // back-to-back host threshold writes, then coefficients
    e = exp_of();
    e.mv = e.mv ^ {6'($random(seed)), 1'b1};
    lwr = 1'b1;
    lmv = e.mv;
    q.push_back(e);
    @(negedge sys_clk_i);
    e.mv = e.mv ^ 7'h40;
    lmv = e.mv;
    q.push_back(e);
    @(negedge sys_clk_i);
    lwr = 1'b0;
    cwr = 1'b1;
    kp = 12'($random(seed));
    ki = 12'($random(seed));
    e.ch = 1'b1;
    q.push_back(e);
    @(negedge sys_clk_i);
    cwr = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    cfg(CLC_LVL_RES, 5'h0c, CLC_LVL_RES, 5'h01, CLC_LVL_OPEN);
    run = 1'b1;
    vb = 12'h3e0;
    repeat (3) @(negedge sys_clk_i);
    chk(fu === 1'b1 && hs === 1'b1 && ls === 1'b0, "fast up");
    vb = 12'h420;
    repeat (3) @(negedge sys_clk_i);
    chk(fd === 1'b1 && ls === 1'b1 && hs === 1'b0, "fast down");
    vb = 12'h3f8;
    repeat (3) @(negedge sys_clk_i);
    chk(fu === 1'b0 && fd === 1'b0, "inside band");
    load = 7'h32;
    repeat (8 * PER) @(negedge sys_clk_i);
    chk(oc === 1'b0, "ringing sampled");
    load = 7'h46;
    repeat (2 * PER - 1) @(negedge sys_clk_i);
    chk(oc === 1'b0, "early fault");
    w = 0;
    while (oc !== 1'b1 && w < 2 * PER) begin
      @(negedge sys_clk_i);
      w++;
    end
    chk(oc === 1'b1, "fault missing");
    load = 7'h00;
    repeat (3) @(negedge sys_clk_i);
    chk(oc === 1'b1 && hs === 1'b0 && ls === 1'b0, "fault not held");
    run = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(q.size() == 0, "results outstanding");
    wrap_up;
  end
endmodule : clc_limit_config_tb
